//--- logic/scu_defines.vh
`ifndef SCU_DEFINES_VH
`define SCU_DEFINES_VH

// clocking
`define SCU_MCLK_HZ          10000000
`define SCU_OSC_HZ           87800
`define SCU_CORE_SLOW_HZ     614000
`define SCU_CORE_FAST_HZ     2460000
`define SCU_BAUD_SLOW        2400
`define SCU_BAUD_FAST        9600
`define SCU_OVERSAMPLE       16

// divider reloads, derived from the rates above (rounded down)
`define SCU_TICK_DIV_SLOW    (`SCU_MCLK_HZ / (`SCU_BAUD_SLOW * `SCU_OVERSAMPLE))
`define SCU_TICK_DIV_FAST    (`SCU_MCLK_HZ / (`SCU_BAUD_FAST * `SCU_OVERSAMPLE))
`define SCU_CORE_HALF_SLOW   (`SCU_MCLK_HZ / (`SCU_CORE_SLOW_HZ * 2))
`define SCU_CORE_HALF_FAST   (`SCU_MCLK_HZ / (`SCU_CORE_FAST_HZ * 2))

// internal i/o ports
`define SCU_PORT_DATA        4'h1
`define SCU_PORT_CTRL        4'h2
`define SCU_CTRL_SPEED_BIT   0
`define SCU_CTRL_RESET       1'b0

// frame and sampling phases (0-based: phases 6, 7 and 8)
`define SCU_DATA_BITS        8
`define SCU_PHASE_VOTE_A     4'h6
`define SCU_PHASE_VOTE_B     4'h7
`define SCU_PHASE_VOTE_C     4'h8
`define SCU_PHASE_LAST       4'hf

// fifo
`define SCU_FIFO_DEPTH       32

`endif

//--- logic/scu_line_sync.v
`timescale 1ns/1ps
`default_nettype none

module scu_line_sync (
  input  wire mclk,
  input  wire arst_n,
  input  wire lineIn,
  output reg  lineLevel_q
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // level changes only once stages two and three agree
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q        <= 1'b1;
      s2_q        <= 1'b1;
      s3_q        <= 1'b1;
      lineLevel_q <= 1'b1;
    end else begin
      s1_q <= lineIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lineLevel_q <= s3_q;
      end
    end
  end

endmodule // scu_line_sync

`default_nettype wire

//--- logic/scu_fifo.v
`timescale 1ns/1ps
`default_nettype none

module scu_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             mclk,
  input  wire             arst_n,
  input  wire             inValid,
  output reg              inReady_q,
  input  wire [WIDTH-1:0] inData,
  output reg              outValid_q,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_q;
  reg [AW-1:0]    rdPtr_q;
  reg [AW:0]      count_q;
  reg [AW:0]      count_d;
  wire            push;
  wire            pop;

  assign push    = inValid & inReady_q;
  assign pop     = outValid_q & outReady;
  assign outData = mem[rdPtr_q];

  always @* begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  // flags kept registered so full and empty are exact each cycle
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_q    <= {AW{1'b0}};
      rdPtr_q    <= {AW{1'b0}};
      count_q    <= {(AW+1){1'b0}};
      inReady_q  <= 1'b1;
      outValid_q <= 1'b0;
    end else begin
      count_q    <= count_d;
      inReady_q  <= (count_d != DEPTH[AW:0]);
      outValid_q <= (count_d != {(AW+1){1'b0}});
      if (push) begin
        wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
      end
    end
  end

  always @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

endmodule // scu_fifo

`default_nettype wire

//--- logic/scu_uart.v
`timescale 1ns/1ps
`default_nettype none
`include "scu_defines.vh"

module scu_uart #(
  parameter FIFO_DEPTH = `SCU_FIFO_DEPTH,
  parameter FIFO_AW    = 5
) (
  input  wire       mclk,
  input  wire       arst_n,
  input  wire       portWrEn,
  input  wire       portRdEn,
  input  wire [3:0] portAddr,
  input  wire [7:0] portWrData,
  output wire       txReady,
  output reg  [7:0] rxData_q,
  output reg        rxAvail_q,
  output reg        rxOverrun_q,
  output reg        rxFrameErr_q,
  output reg        txIrq_q,
  output reg        rxIrq_q,
  output reg        txBusy_q,
  output reg        speedSel_q,
  output reg        coreClk_q,
  input  wire       serialLineIn,
  output reg        serialLineOut_q,
  output reg        serialLineOe_q
);

  localparam TX_IDLE  = 2'b00;
  localparam TX_START = 2'b01;
  localparam TX_DATA  = 2'b10;
  localparam TX_STOP  = 2'b11;

  localparam RX_IDLE  = 2'b00;
  localparam RX_START = 2'b01;
  localparam RX_DATA  = 2'b10;
  localparam RX_STOP  = 2'b11;

  // rates worked out as integers, then cut to the counter widths on purpose
  localparam integer DIV_SLOW_I  = `SCU_TICK_DIV_SLOW;
  localparam integer DIV_FAST_I  = `SCU_TICK_DIV_FAST;
  localparam integer HALF_SLOW_I = `SCU_CORE_HALF_SLOW;
  localparam integer HALF_FAST_I = `SCU_CORE_HALF_FAST;
  localparam integer LAST_BIT_I  = `SCU_DATA_BITS - 1;

  localparam [8:0] DIV_SLOW  = DIV_SLOW_I[8:0];
  localparam [8:0] DIV_FAST  = DIV_FAST_I[8:0];
  localparam [4:0] HALF_SLOW = HALF_SLOW_I[4:0];
  localparam [4:0] HALF_FAST = HALF_FAST_I[4:0];
  localparam [2:0] LAST_BIT  = LAST_BIT_I[2:0];

  // ---------------------------------------------------------------- ports
  wire dataWr;
  wire ctrlWr;
  wire dataRd;

  assign dataWr = portWrEn & (portAddr == `SCU_PORT_DATA);
  assign ctrlWr = portWrEn & (portAddr == `SCU_PORT_CTRL);
  assign dataRd = portRdEn & (portAddr == `SCU_PORT_DATA);

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      speedSel_q <= `SCU_CTRL_RESET;
    end else if (ctrlWr) begin
      speedSel_q <= portWrData[`SCU_CTRL_SPEED_BIT];
    end
  end

  // selected oversample divider, slow rate when the bit is clear
  wire [8:0] tickDiv;
  assign tickDiv = speedSel_q ? DIV_FAST : DIV_SLOW;

  // ------------------------------------------------------- core clock
  // stands in for the pll output; divided from mclk, not a real lock loop
  // a speed change mid half-period ends that half at the new count: early going fast, stretched going slow
  reg  [4:0] coreCnt_q;
  wire [4:0] coreHalf;
  assign coreHalf = speedSel_q ? HALF_FAST : HALF_SLOW;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      coreCnt_q <= 5'h00;
      coreClk_q <= 1'b0;
    end else if (coreCnt_q >= coreHalf - 5'h01) begin
      coreCnt_q <= 5'h00;
      coreClk_q <= ~coreClk_q;
    end else begin
      coreCnt_q <= coreCnt_q + 5'h01;
    end
  end

  // ------------------------------------------------------- transmit fifo
  wire       fifoValid;
  wire [7:0] fifoData;
  wire       txTake;

  scu_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_txFifo (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .inValid    (dataWr),
    .inReady_q  (txReady),
    .inData     (portWrData),
    .outValid_q (fifoValid),
    .outReady   (txTake),
    .outData    (fifoData)
  );

  // ------------------------------------------------------- transmitter
  reg [1:0] txState_q;
  reg [8:0] txDiv_q;
  reg [3:0] txPhase_q;
  reg [2:0] txBit_q;
  reg [7:0] txShift_q;
  wire      txTick;
  wire      txBitEnd;

  // queue empty and idle means a port write goes out right away
  assign txTake   = (txState_q == TX_IDLE);
  assign txTick   = (txDiv_q == 9'h000);
  assign txBitEnd = txTick & (txPhase_q == `SCU_PHASE_LAST);

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      txState_q       <= TX_IDLE;
      txDiv_q         <= 9'h000;
      txPhase_q       <= 4'h0;
      txBit_q         <= 3'h0;
      txShift_q       <= 8'h00;
      txIrq_q         <= 1'b0;
      txBusy_q        <= 1'b0;
      serialLineOut_q <= 1'b1;
      serialLineOe_q  <= 1'b0;
    end else begin
      txIrq_q <= 1'b0;
      if (txState_q != TX_IDLE) begin
        txDiv_q <= txTick ? tickDiv - 9'h001 : txDiv_q - 9'h001;
        if (txTick) begin
          txPhase_q <= txPhase_q + 4'h1;
        end
      end
      case (txState_q)
        TX_IDLE: begin
          serialLineOut_q <= 1'b1;
          serialLineOe_q  <= 1'b0;
          txBusy_q        <= 1'b0;
          if (fifoValid) begin
            txShift_q       <= fifoData;
            txDiv_q         <= tickDiv - 9'h001;
            txPhase_q       <= 4'h0;
            txBit_q         <= 3'h0;
            serialLineOut_q <= 1'b0;
            serialLineOe_q  <= 1'b1;
            txBusy_q        <= 1'b1;
            txState_q       <= TX_START;
          end
        end
        TX_START: begin
          if (txBitEnd) begin
            serialLineOut_q <= txShift_q[0];
            txShift_q       <= {1'b0, txShift_q[7:1]};
            txState_q       <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (txBitEnd) begin
            if (txBit_q == LAST_BIT) begin
              serialLineOut_q <= 1'b1;
              txIrq_q         <= 1'b1;
              txState_q       <= TX_STOP;
            end else begin
              serialLineOut_q <= txShift_q[0];
              txShift_q       <= {1'b0, txShift_q[7:1]};
              txBit_q         <= txBit_q + 3'h1;
            end
          end
        end
        TX_STOP: begin
          // line stays driven high for the full stop bit, then released
          if (txBitEnd) begin
            serialLineOe_q <= 1'b0;
            txState_q      <= TX_IDLE;
          end
        end
        default: begin
          txState_q <= TX_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------- receiver
  // own divider and state; start detection is masked while the transmitter drives the pin
  wire lineLevel;
  reg  linePrev_q;

  scu_line_sync u_lineSync (
    .mclk        (mclk),
    .arst_n      (arst_n),
    .lineIn      (serialLineIn),
    .lineLevel_q (lineLevel)
  );

  reg  [1:0] rxState_q;
  reg  [8:0] rxDiv_q;
  reg  [3:0] rxPhase_q;
  reg  [2:0] rxBit_q;
  reg  [7:0] rxShift_q;
  reg  [1:0] rxVote_q;
  wire       rxTick;
  wire       rxDecide;
  wire       rxMajority;
  wire       rxBitEnd;
  wire       rxFall;

  // own echo while driving is ignored: the pin is shared
  assign rxFall     = linePrev_q & ~lineLevel & ~serialLineOe_q;
  assign rxTick     = (rxDiv_q == 9'h000);
  assign rxDecide   = rxTick & (rxPhase_q == `SCU_PHASE_VOTE_C);
  assign rxBitEnd   = rxTick & (rxPhase_q == `SCU_PHASE_LAST);
  assign rxMajority = (rxVote_q[0] & rxVote_q[1]) | (rxVote_q[0] & lineLevel)
                    | (rxVote_q[1] & lineLevel);

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      linePrev_q <= 1'b1;
    end else begin
      linePrev_q <= lineLevel;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rxState_q    <= RX_IDLE;
      rxDiv_q      <= 9'h000;
      rxPhase_q    <= 4'h0;
      rxBit_q      <= 3'h0;
      rxShift_q    <= 8'h00;
      rxVote_q     <= 2'b00;
      rxData_q     <= 8'h00;
      rxAvail_q    <= 1'b0;
      rxOverrun_q  <= 1'b0;
      rxFrameErr_q <= 1'b0;
      rxIrq_q      <= 1'b0;
    end else begin
      rxIrq_q <= 1'b0;
      // a read empties the holding register; a landing byte below wins
      if (dataRd) begin
        rxAvail_q    <= 1'b0;
        rxOverrun_q  <= 1'b0;
        rxFrameErr_q <= 1'b0;
      end
      if (rxState_q != RX_IDLE) begin
        rxDiv_q <= rxTick ? tickDiv - 9'h001 : rxDiv_q - 9'h001;
        if (rxTick) begin
          rxPhase_q <= rxPhase_q + 4'h1;
          if (rxPhase_q == `SCU_PHASE_VOTE_A) begin
            rxVote_q[0] <= lineLevel;
          end
          if (rxPhase_q == `SCU_PHASE_VOTE_B) begin
            rxVote_q[1] <= lineLevel;
          end
        end
      end
      case (rxState_q)
        RX_IDLE: begin
          if (rxFall) begin
            rxDiv_q   <= tickDiv - 9'h001;
            rxPhase_q <= 4'h0;
            rxBit_q   <= 3'h0;
            rxState_q <= RX_START;
          end
        end
        RX_START: begin
          if (rxDecide && rxMajority) begin
            rxState_q <= RX_IDLE;
          end else if (rxBitEnd) begin
            rxState_q <= RX_DATA;
          end
        end
        RX_DATA: begin
          if (rxDecide) begin
            rxShift_q <= {rxMajority, rxShift_q[7:1]};
          end
          if (rxBitEnd) begin
            if (rxBit_q == LAST_BIT) begin
              rxState_q <= RX_STOP;
            end else begin
              rxBit_q <= rxBit_q + 3'h1;
            end
          end
        end
        RX_STOP: begin
          // finish at mid stop bit so a back-to-back start edge is seen
          if (rxDecide) begin
            rxState_q <= RX_IDLE;
            if (rxMajority) begin
              rxData_q    <= rxShift_q;
              rxAvail_q   <= 1'b1;
              rxOverrun_q <= rxAvail_q & ~dataRd;
              rxIrq_q     <= 1'b1;
            end else begin
              rxFrameErr_q <= 1'b1;
            end
          end
        end
        default: begin
          rxState_q <= RX_IDLE;
        end
      endcase
    end
  end

  // the two interrupt lines stay apart so the core can vector them
  // transmit and receive machines share the divider reload, and serialLineOe_q masks the receive start edge

endmodule // scu_uart

`default_nettype wire

//--- tb/scu_uart_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "scu_defines.vh"
module scu_uart_chk #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW    = 5
) (
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic       portWrEn,
  input wire logic       portRdEn,
  input wire logic [3:0] portAddr,
  input wire logic [7:0] portWrData,
  input wire logic       txReady,
  input wire logic [7:0] rxData_q,
  input wire logic       rxAvail_q,
  input wire logic       rxOverrun_q,
  input wire logic       rxFrameErr_q,
  input wire logic       txIrq_q,
  input wire logic       rxIrq_q,
  input wire logic       txBusy_q,
  input wire logic       speedSel_q,
  input wire logic       serialLineOut_q,
  input wire logic       serialLineOe_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  localparam int BitSlow = `SCU_TICK_DIV_SLOW * `SCU_OVERSAMPLE;
  localparam int BitFast = `SCU_TICK_DIV_FAST * `SCU_OVERSAMPLE;
  logic [15:0] lowCnt_q;
  // length of the current driven-low run, a whole number of bits
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) lowCnt_q <= 16'h0;
    else if (serialLineOe_q && !serialLineOut_q) lowCnt_q <= lowCnt_q + 16'h1;
    else lowCnt_q <= 16'h0;
  end
  sequence s_txWr;
    portWrEn && portAddr == `SCU_PORT_DATA && txReady && !txBusy_q && !serialLineOe_q;
  endsequence
  sequence s_txGo;
    ##2 txBusy_q && serialLineOe_q && !serialLineOut_q;
  endsequence
  property p_txStart; s_txWr |-> s_txGo; endproperty
  a_txStart: assert property (p_txStart) else $error("frame late after write");
  property p_txIrqStop; txIrq_q |-> (serialLineOe_q && serialLineOut_q)[*8]; endproperty
  a_txIrqStop: assert property (p_txIrqStop) else $error("tx irq off stop bit");
  property p_bitLen;
    $rose(serialLineOut_q) && serialLineOe_q
      |-> lowCnt_q % (speedSel_q ? BitFast : BitSlow) == 0;
  endproperty
  a_bitLen: assert property (p_bitLen) else $error("bit length wrong");
  property p_rxIrq; rxIrq_q |-> rxAvail_q ##1 !rxIrq_q; endproperty
  a_rxIrq: assert property (p_rxIrq) else $error("rx irq malformed");
  property p_overrun;
    rxIrq_q && $past(rxAvail_q) && !$past(portRdEn && portAddr == `SCU_PORT_DATA)
      |-> rxOverrun_q;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");
  property p_readClr;
    portRdEn && portAddr == `SCU_PORT_DATA
      |=> rxIrq_q || !(rxAvail_q || rxOverrun_q || rxFrameErr_q);
  endproperty
  a_readClr: assert property (p_readClr) else $error("read did not clear");
  property p_rxHold; !rxIrq_q |-> $stable(rxData_q); endproperty
  a_rxHold: assert property (p_rxHold) else $error("rx data moved");
  property p_oeBusy; serialLineOe_q |-> txBusy_q; endproperty
  a_oeBusy: assert property (p_oeBusy) else $error("pin driven while idle");
  property p_release; $fell(serialLineOe_q) |-> $past(serialLineOut_q); endproperty
  a_release: assert property (p_release) else $error("released while low");
  property p_speed;
    portWrEn && portAddr == `SCU_PORT_CTRL |=> speedSel_q == $past(portWrData[0]);
  endproperty
  a_speed: assert property (p_speed) else $error("speed bit not taken");
endmodule // scu_uart_chk

bind scu_uart scu_uart_chk #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) i_chk (.*);
`default_nettype wire

//--- tb/scu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "scu_defines.vh"
module scu_host_model (
  input  wire logic mclk,
  input  wire logic line,
  input  wire logic devOe,
  output var  logic hostDrv
);
  int         bitLen = `SCU_TICK_DIV_FAST * `SCU_OVERSAMPLE;
  logic [8:0] gotQ[$];
  initial hostDrv = 1'b1;
  task automatic send(input logic [7:0] b, input logic stp);
    logic [9:0] f;
    @(negedge mclk);
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      hostDrv = f[i];
      repeat (bitLen) @(negedge mclk);
    end
    hostDrv = 1'b1;
  endtask
  task automatic pulse(input int n);
    @(negedge mclk);
    hostDrv = 1'b0;
    repeat (n) @(negedge mclk);
    hostDrv = 1'b1;
  endtask
  // samples bit centres only; stop lands in bit 8
  always @(negedge line) if (devOe) begin : rcv
    logic [8:0] v;
    repeat (bitLen / 2) @(negedge mclk);
    for (int i = 0; i < 9; i++) begin
      repeat (bitLen) @(negedge mclk);
      v[i] = line;
    end
    gotQ.push_back(v);
  end
endmodule // scu_host_model
`default_nettype wire

//--- tb/scu_uart_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "scu_defines.vh"
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin numErrors++; $display("Error %s exp %0h got %0h", n, e, g); end end
module scu_uart_tb_top;
  logic       mclk = 1'b0, arst_n = 1'b0, portWrEn = 1'b0, portRdEn = 1'b0;
  logic [3:0] portAddr = 4'h0;
  logic [7:0] portWrData = 8'h00, rxData_q, a, b;
  logic       txReady, rxAvail_q, rxOverrun_q, rxFrameErr_q, txIrq_q, rxIrq_q;
  logic       txBusy_q, speedSel_q, coreClk_q, serialLineOut_q, serialLineOe_q, hostDrv;
  logic [31:0] seed = 32'h2abea7c6;
  int         numErrors = 0, samplesChecked = 0, cyc = 0, txIrqs = 0, rxIrqs = 0, n;
  wire logic  serialLineIn = serialLineOe_q ? serialLineOut_q : hostDrv;
  always #50 mclk = ~mclk;
  scu_uart i_dut (.*);
  scu_host_model i_host (.mclk, .line(serialLineIn), .devOe(serialLineOe_q), .hostDrv);
  always @(posedge mclk) begin
    txIrqs += txIrq_q;
    rxIrqs += rxIrq_q;
    cyc++;
    if (cyc == 95000) begin
      numErrors++;
      endOfTest();
    end
  end
  function automatic logic [7:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [8:0] frm(input logic [7:0] d);
    return {1'b1, d};
  endfunction
  task automatic io(input logic rd, input logic [3:0] ad, input logic [7:0] d);
    @(negedge mclk);
    portRdEn = rd;
    portWrEn = !rd;
    portAddr = ad;
    portWrData = d;
    @(negedge mclk);
    {portRdEn, portWrEn} = 2'b00;
  endtask
  task automatic lowLen(output int k);
    @(negedge serialLineOut_q);
    k = -1;
    while (!serialLineOut_q) begin
      @(negedge mclk);
      k++;
    end
  endtask
  task automatic endOfTest();
    $display("errors %0d checks %0d", numErrors, samplesChecked);
    if (numErrors == 0 && samplesChecked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    arst_n = 1'b1;
    io(0, `SCU_PORT_CTRL, 8'h00);
    io(0, `SCU_PORT_DATA, 8'h01);
    lowLen(n);
    `CHK("slowBit", `SCU_TICK_DIV_SLOW * `SCU_OVERSAMPLE, n)
    n = 0;
    while (txReady === 1'b1 && n < 40) begin
      io(0, `SCU_PORT_DATA, nxt());
      n++;
    end
    `CHK("fill", `SCU_FIFO_DEPTH, n)
    // abort the slow frame; rerun at the fast rate to keep the run short
    arst_n = 1'b0;
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    disable i_host.rcv;
    i_host.gotQ.delete();
    `CHK("oeIdle", 1'b0, serialLineOe_q)
    `CHK("ready", 1'b1, txReady)
    io(0, `SCU_PORT_CTRL, 8'h01);
    `CHK("speed", 1'b1, speedSel_q)
    @(posedge coreClk_q);
    n = -1;
    while (coreClk_q) begin
      @(negedge mclk);
      n++;
    end
    `CHK("coreHalf", `SCU_CORE_HALF_FAST, n)
    io(0, `SCU_PORT_DATA, 8'h01);
    lowLen(n);
    `CHK("fastBit", `SCU_TICK_DIV_FAST * `SCU_OVERSAMPLE, n)
    a = nxt();
    io(0, `SCU_PORT_DATA, a);
    wait (i_host.gotQ.size() == 2);
    `CHK("tx0", frm(8'h01), i_host.gotQ[0])
    `CHK("tx1", frm(a), i_host.gotQ[1])
    wait (txBusy_q === 1'b0);
    `CHK("txIrqs", 2, txIrqs)
    a = nxt();
    i_host.send(a, 1'b1);
    repeat (20) @(negedge mclk);
    `CHK("rx0", a, rxData_q)
    `CHK("rxIrqs", 1, rxIrqs)
    b = nxt();
    i_host.send(b, 1'b1);
    repeat (20) @(negedge mclk);
    `CHK("rx1", b, rxData_q)
    `CHK("ovr", 1'b1, rxOverrun_q)
    io(1, `SCU_PORT_DATA, 8'h00);
    `CHK("avail", 1'b0, rxAvail_q)
    `CHK("ovrClr", 1'b0, rxOverrun_q)
    i_host.pulse(3);
    repeat (50) @(negedge mclk);
    i_host.pulse(200);
    repeat (1040) @(negedge mclk);
    `CHK("spike", 1'b0, rxAvail_q)
    a = nxt();
    i_host.send(a, 1'b1);
    repeat (20) @(negedge mclk);
    `CHK("rx2", a, rxData_q)
    `CHK("rxIrqs", 3, rxIrqs)
    i_host.send(nxt(), 1'b0);
    repeat (20) @(negedge mclk);
    `CHK("ferr", 1'b1, rxFrameErr_q)
    `CHK("rxIrqs", 3, rxIrqs)
    endOfTest();
  end
endmodule // scu_uart_tb_top
`default_nettype wire
